// ---- design/bgr_pkg.sv ----
package bgr_pkg;
    localparam int          VAL_W     = 21;
    localparam int          NUM_W     = 28;
    localparam int          DEN_W     = 24;
    localparam int          SP_N      = 6;
    localparam int          TBL_N     = 32;
    localparam int          ITEM_N    = 10;
    localparam logic [6:0]  SEG_TOP   = 7'h64;
    localparam logic [6:0]  TBL_TOP   = 7'h1F;
    // Register byte offsets
    localparam logic [7:0]  ADR_CODE  = 8'h00;
    localparam logic [7:0]  ADR_LO    = 8'h04;
    localparam logic [7:0]  ADR_HI    = 8'h08;
    localparam logic [7:0]  ADR_NOM   = 8'h0C;
    localparam logic [7:0]  ADR_REF   = 8'h10;
    localparam logic [7:0]  ADR_ZONES = 8'h14;
    localparam logic [7:0]  ADR_STAT  = 8'h18;
    localparam logic [7:0]  ADR_SP    = 8'h20;
    localparam logic [7:0]  ADR_TBL   = 8'h80;
    // Setting code digit positions
    localparam int          D1_POS    = 8;
    localparam int          D2_POS    = 4;
    localparam int          D3_POS    = 0;
    localparam logic [3:0]  D1_COLOUR = 4'h2;
    localparam logic [3:0]  D1_SCALE  = 4'h3;
    localparam logic [3:0]  SC_LIN    = 4'h0;
    localparam logic [3:0]  SC_TBL    = 4'h1;
    localparam logic [3:0]  FMT_SP    = 4'h0;
    localparam logic [3:0]  FMT_PV    = 4'h1;
    localparam logic [3:0]  FMT_MM    = 4'h4;
    localparam logic [3:0]  FMT_BAR   = 4'h7;
    localparam logic [1:0]  COL_OFF   = 2'h0;
    // Count limits and reset values
    localparam logic signed [31:0] CNT_MIN = 32'hFFFCF2C1;
    localparam logic signed [31:0] CNT_MAX = 32'h000F423F;
    localparam logic signed [31:0] REF_MIN = 32'h00000001;
    localparam logic [3:0]  FMT_RST   = 4'h7;
    localparam logic [11:0] CODE_RST  = 12'h070;
    localparam logic [20:0] LO_RST    = 21'h000000;
    localparam logic [20:0] HI_RST    = 21'h0003E8;
    localparam logic [20:0] REF_RST   = 21'h000001;
    localparam logic [13:0] ZONE_RST  = 14'h1555;
    localparam logic [2:0]  DEC_MAX   = 3'h6;
    localparam logic [23:0] TEN       = 24'h00000A;

    // Bars per decade from the third digit
    function automatic logic [6:0] bpdOf(input logic [3:0] d3);
        case (d3)
            4'h3:    bpdOf = 7'h0A;
            4'h4:    bpdOf = 7'h14;
            4'h5:    bpdOf = 7'h19;
            4'h6:    bpdOf = 7'h21;
            4'h7:    bpdOf = 7'h32;
            default: bpdOf = 7'h00;
        endcase
    endfunction
endpackage

// ---- design/bgr_table_mem.sv ----
`timescale 1ns/10ps
// Linearization points, one write port and two registered read ports
module bgr_table_mem
    import bgr_pkg::*;
#(
    parameter int DEPTH = TBL_N,
    parameter int WIDTH = VAL_W
) (
    input  wire logic                     clk,
    input  wire logic                     wrEn,
    input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input  wire logic [WIDTH-1:0]         wrData,
    input  wire logic [$clog2(DEPTH)-1:0] rdAddrA,
    output logic      [WIDTH-1:0]         rdDataA,
    input  wire logic [$clog2(DEPTH)-1:0] rdAddrB,
    output logic      [WIDTH-1:0]         rdDataB
);
    logic [WIDTH-1:0] mem [DEPTH];

    // No reset on contents: software loads the table
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdDataA <= mem[rdAddrA];
        rdDataB <= mem[rdAddrB];
    end
endmodule

// ---- design/bgr_round_div.sv ----
`timescale 1ns/10ps
// Sequential divider returning num/den rounded to nearest
module bgr_round_div
    import bgr_pkg::*;
#(
    parameter int NW = NUM_W,
    parameter int DW = DEN_W
) (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          start,
    input  wire logic [NW-1:0] num,
    input  wire logic [DW-1:0] den,
    output logic      [NW-1:0] quo,
    output logic               done
);
    logic [DW:0]           remQ;
    logic [$clog2(NW):0]   cntQ;
    logic                  busyQ;
    logic [DW:0]           remS;

    assign remS = {remQ[DW-1:0], quo[NW-1]};

    // Half the divisor is added first so truncation rounds
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            remQ  <= '0;
            quo   <= '0;
            cntQ  <= '0;
            busyQ <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                remQ  <= '0;
                quo   <= num + NW'(den >> 1);
                cntQ  <= ($clog2(NW)+1)'(NW);
                busyQ <= (den != '0);
                done  <= (den == '0);
                if (den == '0) begin
                    quo <= '0;
                end
            end else if (busyQ) begin
                if (remS >= {1'b0, den}) begin
                    remQ <= remS - {1'b0, den};
                    quo  <= {quo[NW-2:0], 1'b1};
                end else begin
                    remQ <= remS;
                    quo  <= {quo[NW-2:0], 1'b0};
                end
                cntQ <= cntQ - 1'b1;
                if (cntQ == ($clog2(NW)+1)'(1)) begin
                    busyQ <= 1'b0;
                    done  <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- design/bgr_renderer.sv ----
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module bgr_renderer
    import bgr_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic signed [VAL_W-1:0] sigValue,
    input  wire logic signed [VAL_W-1:0] peakValue,
    input  wire logic signed [VAL_W-1:0] valleyValue,
    input  wire logic [SP_N-1:0]         spActive,
    input  wire logic [SP_N-1:0]         spSameSource,
    output logic      [100:0]            segOn,
    output logic      [1:0]              barColour
);
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_PREP  = 3'b001,
        S_DIV   = 3'b011,
        S_STORE = 3'b010,
        S_SHOW  = 3'b110,
        S_LOG   = 3'b111,
        S_TBL   = 3'b101
    } bgr_state_t;

    bgr_state_t               stQ;
    logic [11:0]              codeQ;
    logic [3:0]               setupQ, fmtQ, scaleQ;
    logic signed [VAL_W-1:0]  loQ, hiQ, nomQ, refQ;
    logic signed [VAL_W-1:0]  spValQ [SP_N];
    logic [13:0]              zoneQ;
    logic                     pendQ, ackQ;
    logic [31:0]              datQ, wrWord, rdWord;
    logic [20:0]              tblRdA, tblRdB;
    logic [6:0]               posQ [ITEM_N];
    logic [3:0]               itemQ;
    logic                     tblPhQ, divStartQ, divDone;
    logic [NUM_W-1:0]         divNumQ, divQuo;
    logic [DEN_W-1:0]         divDenQ, decQ;
    logic [2:0]               decKQ;
    logic [SP_N-1:0]          spPrevQ;
    logic [2:0]               lastSpQ, zone;
    logic                     lastUpQ, lastValidQ;
    logic [100:0]             segQ, segD;
    logic [1:0]               colQ, colD;
    logic signed [VAL_W-1:0]  itemV, clampV, tblV;
    logic [6:0]               bpd, barLo, barHi, sigP, nomP;
    logic                     wrEn, isLog, nomAtTop;

    assign wb_dat_o  = datQ;
    assign wb_ack_o  = ackQ;
    assign segOn     = segQ;
    assign barColour = colQ;

    // Byte-lane merge, then limit to the given window
    function automatic logic [31:0] wbMerge(input logic [31:0] old);
        for (int b = 0; b < 4; b++) begin
            old[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8] : old[8*b +: 8];
        end
        return old;
    endfunction

    function automatic logic signed [VAL_W-1:0] clampTo(input logic signed [31:0] v,
                                                        input logic signed [31:0] lo,
                                                        input logic signed [31:0] hi);
        logic signed [31:0] r;
        r = (v < lo) ? lo : ((v > hi) ? hi : v);
        return r[VAL_W-1:0];
    endfunction

    // Ascending position of a setpoint among those on the bar source
    function automatic logic [2:0] spRank(input logic [2:0] j);
        logic [2:0] r;
        r = 3'h0;
        for (int k = 0; k < SP_N; k++) begin
            if (spSameSource[k] && (spValQ[k] < spValQ[j] ||
                (spValQ[k] == spValQ[j] && 3'(k) < j))) begin
                r = r + 3'h1;
            end
        end
        return r;
    endfunction

    // Bus answers on the second edge so table reads can be registered;
    // a write lands only at the edge where the master sees ack high
    assign wrEn = wb_cyc_i & wb_stb_i & wb_we_i & ackQ;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pendQ <= 1'b0;
            ackQ  <= 1'b0;
        end else begin
            pendQ <= wb_cyc_i & wb_stb_i & ~pendQ & ~ackQ;
            ackQ  <= wb_cyc_i & wb_stb_i & pendQ;
        end
    end

    // Read mux; unmapped words read as zero
    always_comb begin
        rdWord = 32'h0;
        if (wb_adr_i >= ADR_TBL) begin
            rdWord = 32'(signed'(tblRdA));
        end else if (wb_adr_i >= ADR_SP && wb_adr_i < ADR_SP + 8'h18) begin
            rdWord = 32'(spValQ[3'(wb_adr_i[4:2])]);
        end else begin
            case (wb_adr_i)
                ADR_CODE:  rdWord = {20'h0, codeQ};
                ADR_LO:    rdWord = 32'(loQ);
                ADR_HI:    rdWord = 32'(hiQ);
                ADR_NOM:   rdWord = 32'(nomQ);
                ADR_REF:   rdWord = 32'(refQ);
                ADR_ZONES: rdWord = {18'h0, zoneQ};
                ADR_STAT:  rdWord = {16'h0, 3'(stQ), zone, colQ, 1'b0, posQ[0]};
                default:   rdWord = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            datQ <= 32'h0;
        end else if (pendQ) begin
            datQ <= rdWord;
        end
    end

    assign wrWord = wbMerge(rdWord);

    // Setting code: mode from digit one, format and scaling latched
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            codeQ  <= CODE_RST;
            setupQ <= 4'h0;
            fmtQ   <= FMT_RST;
            scaleQ <= SC_LIN;
        end else if (wrEn && wb_adr_i == ADR_CODE) begin
            codeQ  <= wrWord[11:0];
            setupQ <= wrWord[D1_POS +: 4];
            if (wrWord[D1_POS +: 4] != D1_COLOUR) begin
                fmtQ <= wrWord[D2_POS +: 4];
            end
            if (wrWord[D1_POS +: 4] == D1_SCALE) begin
                scaleQ <= wrWord[D3_POS +: 4];
            end
        end
    end

    // Scaling words change only in scaling setup, colours in colour setup
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            loQ   <= LO_RST;
            hiQ   <= HI_RST;
            nomQ  <= LO_RST;
            refQ  <= REF_RST;
            zoneQ <= ZONE_RST;
        end else if (wrEn) begin
            if (setupQ == D1_SCALE) begin
                case (wb_adr_i)
                    ADR_LO:  loQ  <= clampTo(wrWord, CNT_MIN, CNT_MAX);
                    ADR_HI:  hiQ  <= clampTo(wrWord, CNT_MIN, CNT_MAX);
                    ADR_NOM: nomQ <= clampTo(wrWord, CNT_MIN, CNT_MAX);
                    ADR_REF: refQ <= clampTo(wrWord, REF_MIN, CNT_MAX);
                    default: ;
                endcase
            end
            if (setupQ == D1_COLOUR && wb_adr_i == ADR_ZONES) begin
                zoneQ <= wrWord[13:0];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int j = 0; j < SP_N; j++) begin
                spValQ[j] <= LO_RST;
            end
        end else if (wrEn && wb_adr_i >= ADR_SP && wb_adr_i < ADR_SP + 8'h18) begin
            spValQ[3'(wb_adr_i[4:2])] <= clampTo(wrWord, CNT_MIN, CNT_MAX);
        end
    end

    bgr_table_mem u_tbl (
        .clk     (clk),
        .wrEn    (wrEn && setupQ == D1_SCALE && wb_adr_i >= ADR_TBL),
        .wrAddr  (wb_adr_i[6:2]),
        .wrData  (wrWord[20:0]),
        .rdAddrA (wb_adr_i[6:2]),
        .rdDataA (tblRdA),
        .rdAddrB (divQuo[4:0]),
        .rdDataB (tblRdB)
    );

    bgr_round_div u_div (
        .clk   (clk),
        .reset (reset),
        .start (divStartQ),
        .num   (divNumQ),
        .den   (divDenQ),
        .quo   (divQuo),
        .done  (divDone)
    );

    // Value of the item being scaled: signal, start, peak, valley, setpoints
    always_comb begin
        case (itemQ)
            4'h0:    itemV = sigValue;
            4'h1:    itemV = nomQ;
            4'h2:    itemV = peakValue;
            4'h3:    itemV = valleyValue;
            default: itemV = spValQ[3'(itemQ - 4'h4)];
        endcase
    end

    assign isLog  = (bpdOf(scaleQ) != 7'h0);
    assign bpd    = bpdOf(scaleQ);
    assign clampV = clampTo(32'(itemV), 32'(loQ), 32'(hiQ));
    assign tblV   = clampTo(32'(signed'(tblRdB)), 32'(loQ), 32'(hiQ));

    // Scaling engine walks all items, then refreshes the segments
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stQ       <= S_IDLE;
            itemQ     <= 4'h0;
            tblPhQ    <= 1'b0;
            divStartQ <= 1'b0;
            divNumQ   <= '0;
            divDenQ   <= '0;
            decQ      <= '0;
            decKQ     <= 3'h0;
            for (int i = 0; i < ITEM_N; i++) begin
                posQ[i] <= 7'h0;
            end
        end else begin
            divStartQ <= 1'b0;
            case (stQ)
                S_IDLE: stQ <= S_PREP;
                S_PREP: begin
                    if (isLog) begin
                        decQ  <= DEN_W'(refQ);
                        decKQ <= 3'h0;
                        stQ   <= (itemV <= refQ) ? S_STORE : S_LOG;
                        divNumQ <= '0;
                    end else begin
                        divNumQ   <= NUM_W'(unsigned'(clampV - loQ)) *
                                     NUM_W'((scaleQ == SC_TBL && itemQ != 4'h1 && itemQ < 4'h4)
                                            ? TBL_TOP : SEG_TOP);
                        divDenQ   <= (hiQ > loQ) ? DEN_W'(hiQ - loQ) : '0;
                        tblPhQ    <= scaleQ == SC_TBL && itemQ != 4'h1 && itemQ < 4'h4;
                        divStartQ <= 1'b1;
                        stQ       <= S_DIV;
                    end
                end
                S_LOG: begin
                    if (DEN_W'(itemV) >= decQ * TEN && decKQ < DEC_MAX) begin
                        decQ  <= decQ * TEN;
                        decKQ <= decKQ + 3'h1;
                    end else begin
                        divNumQ   <= NUM_W'(DEN_W'(itemV) - decQ) * NUM_W'(bpd);
                        divDenQ   <= decQ * DEN_W'(9);
                        divStartQ <= 1'b1;
                        stQ       <= S_DIV;
                    end
                end
                S_DIV: begin
                    if (divDone) begin
                        stQ <= tblPhQ ? S_TBL : S_STORE;
                        divNumQ <= divQuo + (isLog ? NUM_W'(decKQ) * NUM_W'(bpd) : '0);
                    end
                end
                S_TBL: begin
                    tblPhQ    <= 1'b0;
                    divNumQ   <= NUM_W'(unsigned'(tblV - loQ)) * NUM_W'(SEG_TOP);
                    divStartQ <= 1'b1;
                    stQ       <= S_DIV;
                end
                S_STORE: begin
                    posQ[itemQ] <= (divNumQ > NUM_W'(SEG_TOP)) ? SEG_TOP : divNumQ[6:0];
                    itemQ       <= (itemQ == 4'(ITEM_N - 1)) ? 4'h0 : itemQ + 4'h1;
                    stQ         <= (itemQ == 4'(ITEM_N - 1)) ? S_SHOW : S_PREP;
                end
                S_SHOW:  stQ <= S_PREP;
                default: stQ <= S_IDLE;
            endcase
        end
    end

    // Latest setpoint on the bar source to activate, and its direction
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            spPrevQ    <= '0;
            lastSpQ    <= 3'h0;
            lastUpQ    <= 1'b0;
            lastValidQ <= 1'b0;
        end else begin
            spPrevQ <= spActive;
            if (lastUpQ && !(spActive[lastSpQ] && spSameSource[lastSpQ])) begin
                lastUpQ <= 1'b0;
            end
            for (int j = 0; j < SP_N; j++) begin
                if (spActive[j] && !spPrevQ[j] && spSameSource[j]) begin
                    lastSpQ    <= 3'(j);
                    lastUpQ    <= 1'b1;
                    lastValidQ <= 1'b1;
                end
            end
        end
    end

    // Zone 0 below the lowest setpoint up to zone 6 above the highest
    assign zone = lastValidQ ? spRank(lastSpQ) + {2'h0, lastUpQ} : 3'h0;
    assign colD = zoneQ[2*zone +: 2];

    assign sigP     = posQ[0];
    assign nomP     = posQ[1];
    assign nomAtTop = (nomQ >= hiQ);
    assign barLo    = (fmtQ == FMT_MM) ? ((posQ[3] < sigP) ? posQ[3] : sigP)
                                       : ((sigP < nomP) ? sigP : nomP);
    assign barHi    = (fmtQ == FMT_MM) ? ((posQ[2] > sigP) ? posQ[2] : sigP)
                                       : ((sigP > nomP) ? sigP : nomP);

    // One comparison slice per segment
    for (genvar i = 0; i <= 100; i++) begin : g_seg
        localparam logic [6:0] IDX = 7'(i);
        logic inBar, spMark, pvMark;
        assign inBar  = IDX >= barLo && IDX <= barHi &&
                        !(fmtQ != FMT_MM && nomAtTop && sigP == SEG_TOP);
        assign pvMark = (fmtQ == FMT_PV) && (IDX == posQ[2] || IDX == posQ[3]);
        always_comb begin
            spMark = 1'b0;
            for (int j = 0; j < SP_N; j++) begin
                if (spSameSource[j] && IDX == posQ[4 + j]) begin
                    spMark = 1'b1;
                end
            end
        end
        assign segD[i] = (colD != COL_OFF) && (inBar || pvMark ||
                         (spMark && !inBar && (fmtQ == FMT_SP || fmtQ == FMT_MM)));
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            segQ <= '0;
            colQ <= COL_OFF;
        end else if (stQ == S_SHOW) begin
            segQ <= segD;
            colQ <= colD;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !pendQ && !ackQ;
    endsequence
    sequence s_ans;
        !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o;
    endsequence

    property p_wbAck;
        s_req |-> s_ans;
    endproperty
    a_wbAck: assert property (p_wbAck) else $error("bus answer late");

    property p_offDark;
        colQ == COL_OFF |-> segQ == '0;
    endproperty
    a_offDark: assert property (p_offDark) else $error("off colour lit");

    property p_colourMode;
        wrEn && wb_adr_i == ADR_CODE && wrWord[D1_POS +: 4] == D1_COLOUR |=> setupQ == D1_COLOUR && $stable(fmtQ);
    endproperty
    a_colourMode: assert property (p_colourMode) else $error("colour setup wrong");

    property p_span;
        loQ >= CNT_MIN && loQ <= CNT_MAX && hiQ >= CNT_MIN && hiQ <= CNT_MAX;
    endproperty
    a_span: assert property (p_span) else $error("span out of range");

    property p_ref;
        refQ >= REF_MIN && refQ <= CNT_MAX;
    endproperty
    a_ref: assert property (p_ref) else $error("reference out of range");

    property p_pos;
        stQ == S_STORE |=> posQ[$past(itemQ)] <= SEG_TOP;
    endproperty
    a_pos: assert property (p_pos) else $error("position past top");

    property p_single;
        stQ == S_SHOW && fmtQ == FMT_BAR && colD != COL_OFF && sigP == nomP && !nomAtTop
            |=> $countones(segQ) == 1;
    endproperty
    a_single: assert property (p_single) else $error("not one segment");

    property p_topDark;
        stQ == S_SHOW && fmtQ != FMT_MM && nomAtTop && sigP == SEG_TOP |=> segQ == '0;
    endproperty
    a_topDark: assert property (p_topDark) else $error("lit at high end");

    property p_ends;
        stQ == S_SHOW && colD != COL_OFF && !(nomAtTop && sigP == SEG_TOP)
            |=> segQ[$past(sigP)] && (fmtQ == FMT_MM || segQ[$past(nomP)]);
    endproperty
    a_ends: assert property (p_ends) else $error("bar ends dark");
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
module tb_top
    import bgr_pkg::*;
;
    logic                    clk = 1'b0;
    logic                    reset = 1'b1;
    logic                    cyc = 1'b0;
    logic                    stb = 1'b0;
    logic                    we = 1'b0;
    logic [7:0]              adr = 8'h00;
    logic [31:0]             wdat = 32'h00000000;
    logic [31:0]             dat;
    logic [31:0]             rd;
    logic                    ack;
    logic signed [VAL_W-1:0] sig = '0;
    logic signed [VAL_W-1:0] peak = '0;
    logic signed [VAL_W-1:0] valley = '0;
    logic [SP_N-1:0]         spAct = '0;
    logic [SP_N-1:0]         spSame = '0;
    logic [100:0]            seg;
    logic [1:0]              col;
    int                      badCount = 0;
    int                      checksDone = 0;
    int                      cycN = 0;
    logic [6:0]              bpd [5] = '{7'h0A, 7'h14, 7'h19, 7'h21, 7'h32};

    bgr_renderer uut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
        .sigValue(sig), .peakValue(peak), .valleyValue(valley), .spActive(spAct),
        .spSameSource(spSame), .segOn(seg), .barColour(col));

    // 25 MHz clock
    always #20 clk = ~clk;

    // One classic cycle; request held until ack is sampled high
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rd = dat;
        cyc <= 1'b0; stb <= 1'b0;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checksDone++;
        if (g !== e) begin
            badCount++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chkSeg(input logic [100:0] e);
        checksDone++;
        if (seg !== e) begin
            badCount++;
            $display("MISMATCH segOn expected %h seen %h", e, seg);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        wbx(1'b0, a, 32'h00000000);
        chk("register", e, rd);
    endtask

    // Lit segments lo..hi inclusive
    function automatic logic [100:0] span(input int l, input int h);
        span = '0;
        for (int i = l; i <= h; i++) span[i] = 1'b1;
    endfunction

    // Segments only refresh once per engine pass, so settle generously
    task automatic settle(input int v);
        sig <= VAL_W'(v);
        repeat (1000) @(posedge clk);
    endtask

    task automatic results;
        $display("Mismatches %0d, comparisons %0d", badCount, checksDone);
        if (badCount == 0 && checksDone > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycN++;
        if (cycN == 40000) begin
            badCount++;
            results();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rdc(ADR_CODE, 32'h00000070);
        rdc(8'h1C, 32'h00000000);
        wbx(1'b1, ADR_LO, 32'h00000005);
        rdc(ADR_LO, 32'h00000000);
        wbx(1'b1, ADR_CODE, 32'h00000200);
        wbx(1'b1, ADR_ZONES, 32'h00000002);
        rdc(ADR_ZONES, 32'h00000002);
        wbx(1'b1, ADR_CODE, 32'h00000370);
        wbx(1'b1, ADR_HI, 32'h0FFFFFFF);
        rdc(ADR_HI, 32'h000F423F);
        wbx(1'b1, ADR_HI, 32'h00000064);
        settle(50);
        chkSeg(span(0, 50));
        chk("barColour", 32'h00000002, {30'h0, col});
        settle(0);
        chkSeg(span(0, 0));
        wbx(1'b1, ADR_NOM, 32'h00000064);
        settle(60);
        chkSeg(span(60, 100));
        settle(100);
        chkSeg(span(1, 0));
        // One decade above a reference of 1 lands exactly on bpd
        for (int d = 3; d <= 7; d++) begin
            wbx(1'b1, ADR_CODE, 32'h00000370 | d);
            settle(10);
            wbx(1'b0, ADR_STAT, 32'h00000000);
            chk("logPos", {25'h0, bpd[d-3]}, {25'h0, rd[6:0]});
        end
        // Setpoint 1 at 80 lies above setpoint 2 at 30, so ranks swap identities
        wbx(1'b1, ADR_CODE, 32'h00000300);
        wbx(1'b1, ADR_NOM, 32'h00000000);
        wbx(1'b1, ADR_SP, 32'h00000050);
        wbx(1'b1, ADR_SP + 8'h04, 32'h0000001E);
        wbx(1'b1, ADR_CODE, 32'h00000200);
        wbx(1'b1, ADR_ZONES, 32'h00000039);
        spSame <= 6'h03;
        settle(10);
        chkSeg(span(0, 10) | span(30, 30) | span(80, 80));
        chk("barColour", 32'h00000001, {30'h0, col});
        spAct <= 6'h02;
        settle(40);
        chkSeg(span(0, 40) | span(80, 80));
        chk("barColour", 32'h00000002, {30'h0, col});
        // Third setpoint rises too but watches another source
        spAct <= 6'h07;
        settle(90);
        chkSeg(span(0, 90));
        chk("barColour", 32'h00000003, {30'h0, col});
        peak <= 21'h000046;
        valley <= 21'h000014;
        wbx(1'b1, ADR_CODE, 32'h00000340);
        settle(50);
        chkSeg(span(20, 70) | span(80, 80));
        wbx(1'b1, ADR_CODE, 32'h00000310);
        settle(50);
        chkSeg(span(0, 50) | span(70, 70));
        // Table points 6, 16 and 22 serve valley, signal and peak
        wbx(1'b1, 8'h98, 32'h0000000A);
        wbx(1'b1, 8'hC0, 32'h00000021);
        wbx(1'b1, 8'hD8, 32'h00000028);
        rdc(8'hC0, 32'h00000021);
        wbx(1'b1, ADR_CODE, 32'h00000371);
        settle(50);
        chkSeg(span(0, 33));
        results();
    end
endmodule
